// >>> rtl/dpcblk_evt_if.sv
// Interface carrying a containment trigger event between the detector and the register file.
`timescale 1ns/100ps
interface dpcblk_evt_if;
    logic fire;
    logic [1:0] reason;
    logic [15:0] src_id;
    modport src (output fire, output reason, output src_id);
    modport dst (input fire, input reason, input src_id);
endinterface

// >>> rtl/dpcblk_msgout.sv
// Emits one-cycle interrupt and correctable-error message requests per trigger.
`timescale 1ns/100ps
module dpcblk_msgout
    import dpcblk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic int_en,
    input wire logic cor_en,
    dpcblk_evt_if.dst evt,
    output logic msi_req,
    output logic err_cor_req
);
    logic msi_d;
    logic msi_q;
    logic cor_d;
    logic cor_q;

    always_comb
    begin
        msi_d = evt.fire & int_en;
        cor_d = evt.fire & cor_en;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            msi_q <= 1'b0;
            cor_q <= 1'b0;
        end
        else
        begin
            msi_q <= msi_d;
            cor_q <= cor_d;
        end
    end

    assign msi_req = msi_q;
    assign err_cor_req = cor_q;
endmodule

// >>> rtl/dpcblk_pkg.sv
// Package with register map, field positions and reset values for containment.
package dpcblk_pkg;
    localparam logic [11:0] DPCBLK_CAP_HDR_OFS = 12'h250;
    localparam logic [11:0] DPCBLK_CTRL_OFS = 12'h254;
    localparam logic [11:0] DPCBLK_STAT_OFS = 12'h258;
    localparam logic [11:0] DPCBLK_IMASK_OFS = 12'h25C;
    localparam logic [31:0] DPCBLK_CAP_HDR_VAL = 32'h0001001D;
    localparam logic [4:0] DPCBLK_MSI_VEC_RST = 5'h01;
    localparam int DPCBLK_TRIG_EN_LO = 16;
    localparam int DPCBLK_CPL_CTRL_BIT = 18;
    localparam int DPCBLK_INT_EN_BIT = 19;
    localparam int DPCBLK_COR_EN_BIT = 20;
    localparam int DPCBLK_SRC_ID_LO = 16;
    localparam logic [1:0] DPCBLK_TRIG_OFF = 2'h0;
    localparam logic [1:0] DPCBLK_TRIG_FATAL = 2'h1;
    localparam logic [1:0] DPCBLK_TRIG_NONFATAL = 2'h2;
    localparam logic [1:0] DPCBLK_RSN_UNCOR = 2'h0;
    localparam logic [1:0] DPCBLK_RSN_NONFATAL = 2'h1;
    localparam logic [1:0] DPCBLK_RSN_FATAL = 2'h2;
    localparam logic [2:0] DPCBLK_CPL_CA = 3'h4;
    localparam logic [2:0] DPCBLK_CPL_UR = 3'h1;
    localparam logic [3:0] DPCBLK_STAT_RST = 4'h0;
    localparam logic [15:0] DPCBLK_SRC_RST = 16'h0000;

    typedef enum logic [1:0] {
        DPCBLK_ST_IDLE = 2'b01,
        DPCBLK_ST_HELD = 2'b10
    } dpcblk_state_e;
endpackage

// >>> rtl/dpcblk_top.sv
// Downstream port containment block with APB registers.
// Notes on behaviour
// - Trigger-enable 00b disables containment, 11b reserved, resets to disabled.
// - Setting 01b triggers on unmasked uncorrectable error or received fatal message.
// - Setting 10b triggers on uncorrectable error, non-fatal or fatal message.
// - Completions during containment return abort when bit is 0, unsupported when 1.
// - Interrupt enable set makes a trigger raise an interrupt; clear gives none; here irq still rises on a trigger when imask unmasks status bits 0 to 2.
// - Correctable-message enable sends one correctable-error message per trigger.
// - Trigger-status flag sets on every trigger and resets to zero.
// - Reason field records uncorrectable 00b, non-fatal 01b, fatal 10b.
// - Interrupt-status flag sets only when triggered with interrupt enable set.
// - Source-ID field holds the requester ID of a triggering message.
// - Containment registers exist only when the port is a downstream port.
// - Interrupt vector number is read-only and resets to vector one.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module dpcblk_top
    import dpcblk_pkg::*;
#(
    parameter bit DOWNSTREAM = 1'b1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic uncor_err,
    input wire logic nonfatal_msg,
    input wire logic fatal_msg,
    input wire logic [15:0] msg_req_id,
    output logic contained,
    output logic [2:0] cpl_status,
    output logic msi_req,
    output logic [4:0] msi_vector,
    output logic err_cor_req,
    output logic irq
);
    logic [1:0] trig_en_q;
    logic [1:0] trig_en_d;
    logic cpl_ctrl_q;
    logic cpl_ctrl_d;
    logic int_en_q;
    logic int_en_d;
    logic cor_en_q;
    logic cor_en_d;
    logic [3:0] stat_q;
    logic [3:0] stat_d;
    logic [3:0] imask_q;
    logic [3:0] imask_d;
    logic [15:0] src_q;
    logic [15:0] src_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    dpcblk_state_e state_q;
    dpcblk_state_e state_d;
    dpcblk_evt_if evt ();

    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    function automatic logic [3:0] w1c(input logic [3:0] cur, input logic [3:0] clr);
        w1c = cur & ~clr;
    endfunction

    logic wait_q;
    logic wait_d;
    logic [2:0] cpl_q;
    logic [2:0] cpl_d;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    // Writes land only at the edge where pready is high, so a new trigger is never cleared twice.
    assign wr_acc = psel & penable & pwrite & wait_q;
    assign rd_acc = psel & penable & ~pwrite;
    // The capability is absent on an upstream port, so every offset answers as unmapped.
    assign mapped = DOWNSTREAM & (hit(paddr, DPCBLK_CAP_HDR_OFS) | hit(paddr, DPCBLK_CTRL_OFS)
        | hit(paddr, DPCBLK_STAT_OFS) | hit(paddr, DPCBLK_IMASK_OFS));

    dpcblk_trigger u_trig (
        .pclk(pclk),
        .presetn(presetn),
        .trig_en(trig_en_q),
        .contained(contained),
        .uncor_err(uncor_err & DOWNSTREAM),
        .nonfatal_msg(nonfatal_msg & DOWNSTREAM),
        .fatal_msg(fatal_msg & DOWNSTREAM),
        .msg_req_id(msg_req_id),
        .evt(evt.src)
    );

    dpcblk_msgout u_msg (
        .pclk(pclk),
        .presetn(presetn),
        .int_en(int_en_q),
        .cor_en(cor_en_q),
        .evt(evt.dst),
        .msi_req(msi_req),
        .err_cor_req(err_cor_req)
    );

    always_comb
    begin
        trig_en_d = trig_en_q;
        cpl_ctrl_d = cpl_ctrl_q;
        int_en_d = int_en_q;
        cor_en_d = cor_en_q;
        imask_d = imask_q;
        stat_d = stat_q;
        src_d = src_q;
        if (wr_acc && mapped && hit(paddr, DPCBLK_CTRL_OFS) && pstrb[2])
        begin
            trig_en_d = pwdata[DPCBLK_TRIG_EN_LO +: 2];
            cpl_ctrl_d = pwdata[DPCBLK_CPL_CTRL_BIT];
            int_en_d = pwdata[DPCBLK_INT_EN_BIT];
            cor_en_d = pwdata[DPCBLK_COR_EN_BIT];
        end
        if (wr_acc && mapped && hit(paddr, DPCBLK_IMASK_OFS) && pstrb[0])
        begin
            imask_d = pwdata[3:0];
        end
        if (wr_acc && mapped && hit(paddr, DPCBLK_STAT_OFS) && pstrb[0])
        begin
            stat_d = w1c(stat_q, pwdata[3:0]);
        end
        // A trigger in the same cycle as a clear wins, so no event is lost.
        if (evt.fire)
        begin
            stat_d[0] = 1'b1;
            stat_d[2:1] = evt.reason;
            stat_d[3] = stat_d[3] | int_en_q;
            src_d = evt.src_id;
        end
    end

    // Containment is held until software clears the trigger-status flag.
    always_comb
    begin
        case (state_q)
            DPCBLK_ST_IDLE:
            begin
                state_d = evt.fire ? DPCBLK_ST_HELD : DPCBLK_ST_IDLE;
            end
            DPCBLK_ST_HELD:
            begin
                state_d = stat_d[0] ? DPCBLK_ST_HELD : DPCBLK_ST_IDLE;
            end
            default:
            begin
                state_d = DPCBLK_ST_IDLE;
            end
        endcase
    end

    always_comb
    begin
        rdata_d = 32'h00000000;
        err_d = psel & penable & ~mapped;
        if (rd_acc && mapped)
        begin
            if (hit(paddr, DPCBLK_CAP_HDR_OFS))
            begin
                rdata_d = DPCBLK_CAP_HDR_VAL;
            end
            else if (hit(paddr, DPCBLK_CTRL_OFS))
            begin
                rdata_d[4:0] = DPCBLK_MSI_VEC_RST;
                rdata_d[DPCBLK_TRIG_EN_LO +: 2] = trig_en_q;
                rdata_d[DPCBLK_CPL_CTRL_BIT] = cpl_ctrl_q;
                rdata_d[DPCBLK_INT_EN_BIT] = int_en_q;
                rdata_d[DPCBLK_COR_EN_BIT] = cor_en_q;
            end
            else if (hit(paddr, DPCBLK_STAT_OFS))
            begin
                rdata_d[3:0] = stat_q;
                rdata_d[DPCBLK_SRC_ID_LO +: 16] = src_q;
            end
            else
            begin
                rdata_d[3:0] = imask_q;
            end
        end
    end

    // Control fields keep their value until software rewrites byte two of the register.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trig_en_q <= DPCBLK_TRIG_OFF;
            cpl_ctrl_q <= 1'b0;
            int_en_q <= 1'b0;
            cor_en_q <= 1'b0;
        end
        else
        begin
            trig_en_q <= trig_en_d;
            cpl_ctrl_q <= cpl_ctrl_d;
            int_en_q <= int_en_d;
            cor_en_q <= cor_en_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            imask_q <= 4'h0;
        end
        else
        begin
            imask_q <= imask_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q <= DPCBLK_STAT_RST;
            src_q <= DPCBLK_SRC_RST;
        end
        else
        begin
            stat_q <= stat_d;
            src_q <= src_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= DPCBLK_ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdata_q <= 32'h00000000;
            err_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // The status is decoded ahead of its register so it changes with the control bit.
    always_comb
    begin
        cpl_d = cpl_ctrl_d ? DPCBLK_CPL_UR : DPCBLK_CPL_CA;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpl_q <= DPCBLK_CPL_CA;
        end
        else
        begin
            cpl_q <= cpl_d;
        end
    end

    // Read data is registered, so each access takes exactly one wait state.
    always_comb
    begin
        wait_d = psel & penable & ~wait_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_q <= 1'b0;
        end
        else
        begin
            wait_q <= wait_d;
        end
    end

    assign pready = wait_q;
    assign pslverr = wait_q & err_q;
    assign prdata = rdata_q;
    assign contained = (state_q == DPCBLK_ST_HELD);
    assign cpl_status = cpl_q;
    assign msi_vector = DPCBLK_MSI_VEC_RST;
    assign irq = |(stat_q & imask_q);
endmodule

// >>> rtl/dpcblk_trigger.sv
// Trigger detector choosing a cause and capturing the message requester ID.
`timescale 1ns/100ps
module dpcblk_trigger
    import dpcblk_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] trig_en,
    input wire logic contained,
    input wire logic uncor_err,
    input wire logic nonfatal_msg,
    input wire logic fatal_msg,
    input wire logic [15:0] msg_req_id,
    dpcblk_evt_if.src evt
);
    logic fire_d;
    logic fire_q;
    logic [1:0] rsn_d;
    logic [1:0] rsn_q;
    logic [15:0] src_d;
    logic [15:0] src_q;

    // A second trigger while contained is ignored so the first cause is kept.
    // The cycle after a fire is blocked too, since containment only shows one edge later.
    always_comb
    begin
        fire_d = 1'b0;
        rsn_d = rsn_q;
        src_d = src_q;
        if (!contained && !fire_q)
        begin
            case (trig_en)
                DPCBLK_TRIG_FATAL:
                begin
                    fire_d = uncor_err | fatal_msg;
                end
                DPCBLK_TRIG_NONFATAL:
                begin
                    fire_d = uncor_err | fatal_msg | nonfatal_msg;
                end
                default:
                begin
                    fire_d = 1'b0;
                end
            endcase
            if (fire_d)
            begin
                if (uncor_err)
                begin
                    rsn_d = DPCBLK_RSN_UNCOR;
                end
                else if (fatal_msg)
                begin
                    rsn_d = DPCBLK_RSN_FATAL;
                    src_d = msg_req_id;
                end
                else
                begin
                    rsn_d = DPCBLK_RSN_NONFATAL;
                    src_d = msg_req_id;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fire_q <= 1'b0;
            rsn_q <= DPCBLK_RSN_UNCOR;
            src_q <= DPCBLK_SRC_RST;
        end
        else
        begin
            fire_q <= fire_d;
            rsn_q <= rsn_d;
            src_q <= src_d;
        end
    end

    assign evt.fire = fire_q;
    assign evt.reason = rsn_q;
    assign evt.src_id = src_q;
endmodule

// >>> tb/dpcblk_chk.sv
// Checker tying containment outputs to their causes.
`timescale 1ns/100ps
module dpcblk_chk
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic uncor_err,
    input wire logic nonfatal_msg,
    input wire logic fatal_msg,
    input wire logic contained,
    input wire logic [2:0] cpl_status,
    input wire logic msi_req,
    input wire logic [4:0] msi_vector,
    input wire logic err_cor_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_vec;
        msi_vector == 5'h01;
    endproperty
    a_vec: assert property (p_vec) else $error("vector not one");
    property p_cpl;
        cpl_status == 3'h4 || cpl_status == 3'h1;
    endproperty
    a_cpl: assert property (p_cpl) else $error("bad completion status");
    property p_cause;
        $rose(contained) |-> $past(uncor_err || nonfatal_msg || fatal_msg, 2);
    endproperty
    a_cause: assert property (p_cause) else $error("trigger without cause");
    property p_msi;
        msi_req |-> $rose(contained);
    endproperty
    a_msi: assert property (p_msi) else $error("interrupt without trigger");
    property p_cor;
        err_cor_req |-> $rose(contained) ##1 !err_cor_req;
    endproperty
    a_cor: assert property (p_cor) else $error("stray correctable message");
    property p_hold;
        contained && !(psel && penable && pwrite) |=> contained;
    endproperty
    a_hold: assert property (p_hold) else $error("containment dropped");
    property p_rdy;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("access not two cycles");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule

// >>> tb/dpcblk_link.sv
// Behavioural link partner raising errors and error messages.
`timescale 1ns/100ps
module dpcblk_link
(
    input wire logic pclk,
    output logic uncor_err,
    output logic nonfatal_msg,
    output logic fatal_msg,
    output logic [15:0] msg_req_id
);
    initial
    begin
        uncor_err = 1'b0;
        nonfatal_msg = 1'b0;
        fatal_msg = 1'b0;
        msg_req_id = 16'h0000;
    end
    // The ID is inverted after its message so a stale value never looks valid.
    task automatic send(input logic [2:0] kind, input logic [15:0] id);
        begin
            @(posedge pclk);
            uncor_err <= kind[0];
            nonfatal_msg <= kind[1];
            fatal_msg <= kind[2];
            msg_req_id <= id;
            @(posedge pclk);
            uncor_err <= 1'b0;
            nonfatal_msg <= 1'b0;
            fatal_msg <= 1'b0;
            msg_req_id <= ~id;
        end
    endtask
endmodule

// >>> tb/tb.sv
// Self-checking testbench of the containment block.
`timescale 1ns/100ps
module tb;
    import dpcblk_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic uncor_err, nonfatal_msg, fatal_msg, contained, msi_req, err_cor_req, irq;
    logic [15:0] msg_req_id;
    logic [2:0] cpl_status;
    logic [4:0] msi_vector;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int n_msi = 0;
    int n_cor = 0;
    dpcblk_top u_dpcblk_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .uncor_err(uncor_err), .nonfatal_msg(nonfatal_msg), .fatal_msg(fatal_msg),
        .msg_req_id(msg_req_id), .contained(contained), .cpl_status(cpl_status),
        .msi_req(msi_req), .msi_vector(msi_vector), .err_cor_req(err_cor_req),
        .irq(irq));
    dpcblk_link u_link (.pclk(pclk), .uncor_err(uncor_err), .nonfatal_msg(nonfatal_msg),
        .fatal_msg(fatal_msg), .msg_req_id(msg_req_id));
    task automatic conclude();
        begin
            $display("mismatches %0d, comparisons %0d", err_count, checked);
            if (err_count == 0 && checked > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checked++;
            if (seen !== exp)
            begin
                $display("unexpected at %0t: %h, wanted %h", $time, seen, exp);
                err_count++;
            end
        end
    endtask
    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do
                @(posedge pclk);
            while (pready !== 1'b1);
            rd = prdata;
            se = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            #1;
        end
    endtask
    task automatic ev(input logic [2:0] kind, input logic [15:0] id);
        begin
            u_link.send(kind, id);
            repeat (4) @(posedge pclk);
            #1;
        end
    endtask
    task automatic t_reset();
        begin
            apb(1'b0, DPCBLK_CTRL_OFS, 32'h0);
            chk(rd, 32'h00000001);
            apb(1'b0, DPCBLK_STAT_OFS, 32'h0);
            chk(rd, 32'h00000000);
            chk(cpl_status, 3'h4);
            chk(msi_vector, 5'h01);
            apb(1'b0, 12'h300, 32'h0);
            chk(rd, 32'h00000000);
            chk(se, 1'b1);
        end
    endtask
    task automatic t_off();
        begin
            ev(3'b100, 16'h0F0F);
            chk(contained, 1'b0);
            apb(1'b1, DPCBLK_CTRL_OFS, 32'h00030000);
            ev(3'b101, 16'h0F0F);
            chk(contained, 1'b0);
            pstrb <= 4'hB;
            apb(1'b1, DPCBLK_CTRL_OFS, 32'h00190000);
            apb(1'b0, DPCBLK_CTRL_OFS, 32'h0);
            pstrb <= 4'hF;
            chk(rd, 32'h00030001);
        end
    endtask
    task automatic t_fatal();
        begin
            apb(1'b1, DPCBLK_IMASK_OFS, 32'h00000008);
            apb(1'b1, DPCBLK_CTRL_OFS, 32'h00190000);
            ev(3'b010, 16'h5555);
            chk(contained, 1'b0);
            ev(3'b100, 16'h1234);
            chk(contained, 1'b1);
            apb(1'b1, DPCBLK_STAT_OFS, 32'h0);
            apb(1'b0, DPCBLK_STAT_OFS, 32'h0);
            chk(rd, 32'h1234000D);
            chk(n_msi * 16 + n_cor, 17);
            chk(irq, 1'b1);
            apb(1'b1, DPCBLK_IMASK_OFS, 32'h0);
            chk(irq, 1'b0);
            apb(1'b1, DPCBLK_IMASK_OFS, 32'h00000008);
            apb(1'b1, DPCBLK_STAT_OFS, 32'h0000000F);
            apb(1'b0, DPCBLK_STAT_OFS, 32'h0);
            chk({rd[15:0], contained, irq}, 18'h0);
        end
    endtask
    task automatic t_nonfatal();
        begin
            apb(1'b1, DPCBLK_CTRL_OFS, 32'h00060000);
            ev(3'b010, 16'hBEEF);
            apb(1'b0, DPCBLK_STAT_OFS, 32'h0);
            chk(rd, 32'hBEEF0003);
            chk(cpl_status, 3'h1);
            chk(n_msi * 16 + n_cor, 17);
            chk(irq, 1'b0);
            apb(1'b1, DPCBLK_STAT_OFS, 32'h0000000F);
            ev(3'b001, 16'h7777);
            apb(1'b0, DPCBLK_STAT_OFS, 32'h0);
            chk(rd[15:0], 16'h0001);
        end
    endtask
    always @(posedge pclk)
    begin
        n_msi <= n_msi + (msi_req === 1'b1);
        n_cor <= n_cor + (err_cor_req === 1'b1);
        cycles <= cycles + 1;
        if (cycles > 3000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_off();
        t_fatal();
        t_nonfatal();
        conclude();
    end
endmodule
bind dpcblk_top dpcblk_chk u_dpcblk_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .uncor_err(uncor_err), .nonfatal_msg(nonfatal_msg), .fatal_msg(fatal_msg),
    .contained(contained), .cpl_status(cpl_status), .msi_req(msi_req),
    .msi_vector(msi_vector), .err_cor_req(err_cor_req));
